/* hdl/asm_sec_cmd.sv */
/*
 * Security mode command interpreter: set password, unlock, erase prepare and
 * erase unit, with attempt counter, lock, frozen and level state.
 * Assumes a task-file decoder delivering command codes and data-out words on
 * clk, an external media wipe engine, and an asynchronous hardware reset pin.
 * rst is the power-on reset; it clears stored passwords as well.
 */
`timescale 1ns/1ps
`include "asm_cfg.svh"

module asm_sec_cmd (
	// Clock and power-on reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Hardware reset pin, asynchronous
	input  wire logic              hrst_pin,
	// Command from the task-file decoder
	input  wire asm_pkg::asm_cmd_s cmd,
	output logic                   cmd_ready,
	output logic                   cmd_done,
	// Data-out words
	input  wire asm_pkg::asm_word_s dat,
	output logic                   dat_ready,
	// Media wipe engine
	output logic                   erase_req,
	output logic                   erase_enh,
	input  wire logic              erase_done,
	input  wire logic              erase_ok,
	input  wire logic              erase_fault,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata
);
	import asm_pkg::*;

	asm_state_s q;        // Registered state
	asm_state_s d;        // Next state
	logic       cmp_mism; // Password differs from the selected store
	logic [3:0] pw_i;     // Password word index
	logic [15:0] pw_ref;  // Stored word under comparison
	logic       pw_en;    // A password word is arriving

	////////////////////////////////////////////////////////////////////////////
	// Password comparison

	// Word 0 is control, words 1 to 16 the password
	assign pw_i   = 4'(q.widx - `ASM_W_PW_FIRST);
	assign pw_en  = (q.st == ASM_RX) && dat.valid &&
	                (q.widx >= `ASM_W_PW_FIRST) && (q.widx <= `ASM_W_PW_LAST);
	// Identifier picks which stored password is compared
	assign pw_ref = q.ident ? q.master_pw[pw_i] : q.user_pw[pw_i];

	asm_pwd_cmp u_cmp (
		.clk  (clk),
		.rst  (rst),
		.clr  (cmd.valid && cmd_ready),
		.en   (pw_en),
		.a    (dat.data),
		.b    (pw_ref),
		.mism (cmp_mism)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic fin;   // Command completes this cycle
		logic abrt;  // Completion is an abort
		logic flt;   // Completion carries a device fault
		fin  = 1'b0;
		abrt = 1'b0;
		flt  = 1'b0;
		d = q;
		d.erase_req = 1'b0;
		d.done      = 1'b0;
		// Pin synchroniser; only the second stage is used
		d.hs1 = hrst_pin;
		d.hs2 = q.hs1;

		case (q.st)
			// Wait for a command
			ASM_IDLE: begin
				if (cmd.valid) begin
					d.cmd      = cmd.code;
					d.widx     = `ASM_W_CTRL;
					d.was_prep = q.prepared;
					d.prepared = 1'b0;
					case (cmd.code)
						// Non-data prepare finishes at once
						`ASM_CMD_PREP: begin
							fin  = 1'b1;
							abrt = q.frozen;
							d.prepared = !q.frozen;
						end
						// Data-out commands expect one block
						`ASM_CMD_SETPW, `ASM_CMD_UNLOCK, `ASM_CMD_ERASE: begin
							d.st     = ASM_RX;
							d.status = 8'h00;
							d.status[`ASM_ST_DRDY] = 1'b1;
							d.status[`ASM_ST_DRQ]  = 1'b1;
						end
						// Foreign commands only spoil a pending prepare
						default: begin
							d.st = ASM_IDLE;
						end
					endcase
				end
			end

			// Take 256 words; only the first 18 carry meaning
			ASM_RX: begin
				if (dat.valid) begin
					if (q.widx == `ASM_W_CTRL) begin
						d.ident   = dat.data[`ASM_B_IDENT];
						d.lvl_req = dat.data[`ASM_B_LEVEL];
						d.enh_req = dat.data[`ASM_B_ENH];
					end else if (pw_en) begin
						d.stage[pw_i] = dat.data;
					end else if (q.widx == `ASM_W_REV) begin
						d.rev_stage = dat.data;
					end
					d.widx = q.widx + 9'h001;
					if (q.widx == `ASM_W_LAST) begin
						d.st = ASM_EXEC;
						d.status = 8'h00;
						d.status[`ASM_ST_BSY] = 1'b1;
					end
				end
			end

			// Block received: decide the outcome
			ASM_EXEC: begin
				case (q.cmd)
					`ASM_CMD_SETPW: begin
						fin = 1'b1;
						// Locked or frozen devices refuse new passwords
						if (q.frozen || q.locked) begin
							abrt = 1'b1;
						end else if (q.ident) begin
							// Lock and level stay as they are
							d.master_pw = q.stage;
							d.mrev      = q.rev_stage;
						end else begin
							// Lock takes effect at the next hardware reset only
							d.user_pw = q.stage;
							d.pwd_en  = 1'b1;
							d.max_lvl = q.lvl_req;
						end
					end
					`ASM_CMD_UNLOCK: begin
						fin = 1'b1;
						if (q.frozen) begin
							abrt = 1'b1;
						end else if (!q.locked) begin
							abrt = 1'b0;
						end else if (q.tries == `ASM_TRIES_NONE) begin
							abrt = 1'b1;
						end else if (q.ident && q.max_lvl) begin
							abrt = 1'b1;
						end else if (cmp_mism) begin
							abrt    = 1'b1;
							d.tries = q.tries - 3'h1;
						end else begin
							d.locked = 1'b0;
						end
					end
					`ASM_CMD_ERASE: begin
						if (q.frozen || !q.was_prep || q.tries == `ASM_TRIES_NONE ||
						    (q.enh_req && !q.enh_sup)) begin
							fin  = 1'b1;
							abrt = 1'b1;
						end else if (cmp_mism) begin
							fin     = 1'b1;
							abrt    = 1'b1;
							d.tries = q.tries - 3'h1;
						end else begin
							// Hand the wipe to the media engine
							d.erase_req = 1'b1;
							d.st        = ASM_WIPE;
						end
					end
					default: begin
						fin  = 1'b1;
						abrt = 1'b1;
					end
				endcase
			end

			// Media wipe under way
			ASM_WIPE: begin
				if (erase_done) begin
					fin = 1'b1;
					flt = erase_fault;
					if (erase_ok) begin
						// Master password survives the erase
						d.locked = 1'b0;
						d.pwd_en = 1'b0;
					end else begin
						abrt = 1'b1;
					end
				end
			end

			default: begin
				d.st = ASM_IDLE;
			end
		endcase

		// Completion: status and error as the outcome says
		if (fin) begin
			d.st     = ASM_IDLE;
			d.done   = 1'b1;
			d.status = 8'h00;
			d.status[`ASM_ST_DRDY] = 1'b1;
			d.status[`ASM_ST_DF]   = flt;
			d.status[`ASM_ST_ERR]  = abrt;
			d.error  = 8'h00;
			d.error[`ASM_ER_ABRT]  = abrt;
		end

		// Software control: freeze is sticky until a reset
		if (reg_wr && reg_addr == `ASM_REG_CTRL) begin
			d.frozen  = q.frozen | reg_wdata[`ASM_CTRL_FREEZE];
			d.enh_sup = reg_wdata[`ASM_CTRL_ENHSUP];
		end

		// Hardware reset pin: re-arm lock, refill counter, drop command
		if (q.hs2) begin
			d.locked   = q.pwd_en;
			d.tries    = `ASM_TRIES_INIT;
			d.frozen   = 1'b0;
			d.prepared = 1'b0;
			d.st       = ASM_IDLE;
			d.status   = 8'h00;
			d.status[`ASM_ST_DRDY] = 1'b1;
			d.error    = 8'h00;
		end

		// Read data stands one cycle after the strobe
		d.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`ASM_REG_STATUS: d.rdata = {8'h00, q.status};
				`ASM_REG_ERROR:  d.rdata = {8'h00, q.error};
				`ASM_REG_SECST:  d.rdata = {8'h00, q.tries, q.prepared, q.max_lvl,
				                            q.frozen, q.locked, q.pwd_en};
				`ASM_REG_CTRL:   d.rdata = {14'h0000, q.enh_sup, q.frozen};
				`ASM_REG_MREV:   d.rdata = q.mrev;
				default:         d.rdata = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	// Power-on state: unlocked, no passwords, counter full, device ready
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.tries <= `ASM_TRIES_INIT;
			q.status[`ASM_ST_DRDY] <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign cmd_ready = (q.st == ASM_IDLE);
	assign dat_ready = (q.st == ASM_RX);
	assign cmd_done  = q.done;
	assign erase_req = q.erase_req;
	// Zero fill unless the enhanced pattern pass was asked for
	assign erase_enh = q.enh_req;
	assign reg_rdata = q.rdata;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_UNLOCK_FROZEN: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_UNLOCK && q.frozen && !q.hs2
		|=> q.error[`ASM_ER_ABRT] && q.status[`ASM_ST_ERR] && !q.locked == !$past(q.locked))
		else $error("unlock while frozen not aborted");
	AST_PREP_FROZEN: assert property (
		q.st == ASM_IDLE && cmd.valid && cmd.code == `ASM_CMD_PREP && q.frozen && !q.hs2
		|=> q.error[`ASM_ER_ABRT] && !q.prepared)
		else $error("prepare while frozen not aborted");
	AST_TRIES_STEP: assert property (
		q.tries != $past(q.tries) && !$past(q.hs2) |-> q.tries == $past(q.tries) - 3'h1)
		else $error("attempt counter moved by other than one");
	AST_OK_STATUS: assert property (
		q.done && !q.error[`ASM_ER_ABRT] |-> q.status == 8'h40)
		else $error("success status wrong");
	AST_ERR_STATUS: assert property (
		q.done && q.error[`ASM_ER_ABRT]
		|-> q.status[`ASM_ST_ERR] && q.status[`ASM_ST_DRDY] && !q.status[`ASM_ST_BSY]
		    && !q.status[`ASM_ST_DRQ])
		else $error("error status wrong");
	AST_NOPREP: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_ERASE && !q.was_prep && !q.hs2
		|=> q.done && q.error[`ASM_ER_ABRT] && !erase_req)
		else $error("erase without prepare not aborted");
	AST_UNLOCKED_KEEPS: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_UNLOCK && !q.locked && !q.hs2
		|=> $stable(q.tries) ##1 $stable(q.tries))
		else $error("counter changed on unlocked device");
	AST_ERASE_UNLOCKS: assert property (
		q.st == ASM_WIPE && erase_done && erase_ok && !q.hs2
		|=> !q.locked && $stable(q.master_pw) && !q.status[`ASM_ST_ERR])
		else $error("good erase left device locked");
	AST_MAX_MASTER: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_UNLOCK && q.locked && !q.frozen &&
		q.ident && q.max_lvl && !q.hs2 |=> q.locked && q.error[`ASM_ER_ABRT])
		else $error("master unlock at maximum level accepted");
	AST_DRQ_RX: assert property (
		q.st == ASM_RX |-> q.status[`ASM_ST_DRQ] && dat_ready && !q.status[`ASM_ST_BSY])
		else $error("data phase without data request");
	AST_EXHAUSTED: assert property (
		q.st == ASM_EXEC && q.tries == `ASM_TRIES_NONE && !q.hs2 &&
		(q.cmd == `ASM_CMD_ERASE || (q.cmd == `ASM_CMD_UNLOCK && q.locked))
		|=> q.done && q.error[`ASM_ER_ABRT] && q.tries == `ASM_TRIES_NONE && !erase_req)
		else $error("exhausted counter did not abort");
	AST_USER_MISMATCH: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_UNLOCK && q.locked && !q.frozen && !q.ident &&
		q.tries != `ASM_TRIES_NONE && cmp_mism && !q.hs2
		|=> q.locked && q.error[`ASM_ER_ABRT] && q.tries == $past(q.tries) - 3'h1)
		else $error("user password mismatch not aborted");
	AST_MASTER_KEEPS: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_SETPW && q.ident && !q.hs2
		|=> $stable(q.locked) && $stable(q.max_lvl) && $stable(q.pwd_en))
		else $error("master password set changed lock or level");
	AST_ERASE_MISMATCH: assert property (
		q.st == ASM_EXEC && q.cmd == `ASM_CMD_ERASE && cmp_mism && !q.hs2
		|=> q.done && q.error[`ASM_ER_ABRT] && !erase_req)
		else $error("erase with wrong password not aborted");
endmodule

/* hdl/asm_cfg.svh */
/*
 * Constants of the security command block: command codes, field positions,
 * register offsets and power-on values.
 * Assumes it is included by bare name from the design modules and the test files.
 */
// How it works
// - User password, high level: store, lock next reset; here only the hardware reset pin locks, rst clears the password
// - User password, maximum level: master cannot unlock
// - Master password: store it plus word-17 revision
// - Unlock takes one 512-byte data-out block
// - Unlock aborts while frozen
// - Master unlock compares at high, rejected at maximum
// - User mismatch aborts and decrements attempt counter
// - Counter starts five; exhausted blocks unlock, erase
// - Unlock while unlocked leaves counter alone
// - Erase-prepare aborts while frozen, abort flag
// - Erase-unit takes 512 bytes; mismatch aborts
// - Erase-unit without prior prepare is aborted
// - Erase aborts: frozen, unsupported enhanced, wipe failed
// - Normal erase fills user data with zeroes
// - Enhanced erase writes patterns incl. retired sectors
// - Good erase unlocks, master password kept
// - Success: BSY, DF, DRQ, ERR clear; DRDY set; a good wipe here still copies erase_fault into DF
// - Error: ERR with error bits, DF on fault
// - Set block: bit0 user/master, bit8 high/maximum
// - Unlock/erase block: bit0 user/master selection
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

// Command codes
`define ASM_CMD_SETPW   8'hf1
`define ASM_CMD_UNLOCK  8'hf2
`define ASM_CMD_PREP    8'hf3
`define ASM_CMD_ERASE   8'hf4

// Status and error bits
`define ASM_ST_BSY      3'h7
`define ASM_ST_DRDY     3'h6
`define ASM_ST_DF       3'h5
`define ASM_ST_DRQ      3'h3
`define ASM_ST_ERR      3'h0
`define ASM_ER_ABRT     3'h2

// Data block layout, in 16-bit words
`define ASM_W_CTRL      9'h000
`define ASM_W_PW_FIRST  9'h001
`define ASM_W_PW_LAST   9'h010
`define ASM_W_REV       9'h011
`define ASM_W_LAST      9'h0ff
`define ASM_B_IDENT     4'h0
`define ASM_B_ENH       4'h1
`define ASM_B_LEVEL     4'h8

// Unlock attempt counter start
`define ASM_TRIES_INIT  3'h5
`define ASM_TRIES_NONE  3'h0

// Register offsets
`define ASM_REG_STATUS  4'h0
`define ASM_REG_ERROR   4'h1
`define ASM_REG_SECST   4'h2
`define ASM_REG_CTRL    4'h3
`define ASM_REG_MREV    4'h4

// Control register bits
`define ASM_CTRL_FREEZE 3'h0
`define ASM_CTRL_ENHSUP 3'h1

`endif

/* hdl/asm_pkg.sv */
/*
 * Types of the security command block: carriers, states and state records.
 * Assumes asm_cfg.svh is on the include path.
 */
package asm_pkg;

	// Command strobe from the task-file decoder
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} asm_cmd_s;

	// One data-out word
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} asm_word_s;

	// Command sequencer states
	typedef enum logic [2:0] {
		ASM_IDLE,
		ASM_RX,
		ASM_EXEC,
		ASM_WIPE
	} asm_state_e;

	// Comparator state
	typedef struct packed {
		logic mism;
	} asm_cmp_s;

	// Whole state of the command block
	typedef struct packed {
		asm_state_e        st;
		logic [7:0]        cmd;
		logic [8:0]        widx;
		logic              ident;
		logic              lvl_req;
		logic              enh_req;
		logic              was_prep;
		logic [15:0][15:0] user_pw;
		logic [15:0][15:0] master_pw;
		logic [15:0][15:0] stage;
		logic [15:0]       rev_stage;
		logic [15:0]       mrev;
		logic              pwd_en;
		logic              locked;
		logic              frozen;
		logic              max_lvl;
		logic              prepared;
		logic [2:0]        tries;
		logic              enh_sup;
		logic [7:0]        status;
		logic [7:0]        error;
		logic              erase_req;
		logic              done;
		logic [15:0]       rdata;
		logic              hs1;
		logic              hs2;
	} asm_state_s;

endpackage

/* hdl/asm_pwd_cmp.sv */
/*
 * Running password comparator: accumulates a mismatch over streamed words.
 * Assumes clr and en come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "asm_cfg.svh"

module asm_pwd_cmp (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control
	input  wire logic        clr,
	input  wire logic        en,
	// Words to compare
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	// Result
	output logic             mism
);
	import asm_pkg::*;

	asm_cmp_s q;   // Registered state
	asm_cmp_s d;   // Next state

	// Clear starts a new block; any differing word sticks
	always_comb begin
		d = q;
		if (clr) begin
			d.mism = 1'b0;
		end else if (en && (a != b)) begin
			d.mism = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign mism = q.mism;
endmodule

/* test/asm_host_model.sv */
/*
 * Host model: issues task-file commands and 256-word data-out blocks.
 * Assumes send is entered right after a rising clock edge.
 */
`timescale 1ns/1ps
`include "asm_cfg.svh"

module asm_host_model (
	// Clock
	input  wire logic       clk,
	// Handshakes from the device
	input  wire logic       cmd_ready,
	input  wire logic       dat_ready,
	// Requests to the device
	output asm_pkg::asm_cmd_s  cmd,
	output asm_pkg::asm_word_s dat
);
	import asm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Idle lines at time zero
	initial begin
		cmd = '0;
		dat = '0;
	end

	// Block word: control, password, revision, reserved zeroes
	function automatic logic [15:0] blk_word(input int i, input logic [15:0] ctrl,
		input logic [7:0] seed);
		if (i == 0) return ctrl;
		if (i <= 16) return {seed, 8'(i)};
		if (i == 17) return {seed, seed};
		return 16'h0000;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// One command, then its whole block where the code carries one
	task automatic send(input logic [7:0] code, input logic [15:0] ctrl,
		input logic [7:0] seed);
		cmd <= '{valid: 1'b1, code: code};
		do @(posedge clk); while (cmd_ready !== 1'b1);
		// Released lines show the inverse, so stale values never look fresh
		cmd <= '{valid: 1'b0, code: ~code};
		if (code inside {`ASM_CMD_SETPW, `ASM_CMD_UNLOCK, `ASM_CMD_ERASE}) begin
			for (int i = 0; i < 256; i++) begin
				dat <= '{valid: 1'b1, data: blk_word(i, ctrl, seed)};
				do @(posedge clk); while (dat_ready !== 1'b1);
			end
			dat <= '{valid: 1'b0, data: ~blk_word(255, ctrl, seed)};
		end
	endtask
endmodule

/* test/asm_sec_cmd_tb.sv */
/*
 * Self-checking bench of the security command block, with a wipe stub.
 * Assumes the host model drives the command and data ports.
 */
`timescale 1ns/1ps
`include "asm_cfg.svh"

module asm_sec_cmd_tb;
	import asm_pkg::*;

	// Clock, resets and device ports
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hrst_pin = 1'b0;
	asm_cmd_s    cmd;
	asm_word_s   dat;
	logic        cmd_ready;
	logic        cmd_done;
	logic        dat_ready;
	logic        erase_req;
	logic        erase_enh;
	logic        erase_done = 1'b0;
	logic        erase_ok = 1'b0;
	logic        erase_fault = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	// Bench state
	int          wipe_n = 0;
	logic        enh_seen = 1'b0;
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;

	initial forever #4 clk = ~clk;

	asm_sec_cmd asm_sec_cmd_i (.clk(clk), .rst(rst), .hrst_pin(hrst_pin), .cmd(cmd),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .dat(dat), .dat_ready(dat_ready),
		.erase_req(erase_req), .erase_enh(erase_enh), .erase_done(erase_done),
		.erase_ok(erase_ok), .erase_fault(erase_fault), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	asm_host_model asm_host_model_i (.clk(clk), .cmd_ready(cmd_ready),
		.dat_ready(dat_ready), .cmd(cmd), .dat(dat));

	////////////////////////////////////////////////////////////////////////
	// Wipe stub: ends each wipe three cycles after its request
	// One assignment per signal per edge, so the done pulse never races itself
	always @(posedge clk) begin
		if (erase_req === 1'b1) begin
			wipe_n     <= 3;
			enh_seen   <= erase_enh;
			erase_done <= 1'b0;
		end else begin
			wipe_n     <= (wipe_n != 0) ? wipe_n - 1 : 0;
			erase_done <= (wipe_n == 1);
		end
	end

	// Hang guard, well above the length of the sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (fails == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	// Register read; the data stand only in the cycle after the strobe
	task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp,
		input logic [15:0] mask = 16'hffff);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		check($sformatf("reg%0h", a), exp, reg_rdata & mask);
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	// Hardware reset pulse, long enough for the synchroniser
	task automatic hreset();
		hrst_pin <= 1'b1;
		repeat (4) @(posedge clk);
		hrst_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// One command to completion; status and error checked together
	task automatic run(input logic [7:0] code, input logic [15:0] ctrl,
		input logic [7:0] seed, input logic [7:0] st);
		int n;
		asm_host_model_i.send(code, ctrl, seed);
		n = 0;
		while (cmd_done !== 1'b1 && n < 64) begin
			@(posedge clk);
			n++;
		end
		check("cmd_done", 16'h0001, {15'h0000, cmd_done});
		reg_chk(`ASM_REG_STATUS, {8'h00, st});
		reg_chk(`ASM_REG_ERROR, st[0] ? 16'h0004 : 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
		check("dat_ready", 16'h0000, {15'h0000, dat_ready});
		reg_chk(`ASM_REG_STATUS, 16'h0040);
		reg_chk(`ASM_REG_SECST, 16'h00a0);
		reg_chk(4'h7, 16'h0000);
		reg_write(`ASM_REG_STATUS, 16'h00ff);
		reg_chk(`ASM_REG_STATUS, 16'h0040);
		// Passwords at high level, master unchanged lock state
		run(`ASM_CMD_SETPW, 16'h0000, 8'h5a, 8'h40);
		reg_chk(`ASM_REG_SECST, 16'h00a1);
		run(`ASM_CMD_SETPW, 16'h0001, 8'h3c, 8'h40);
		reg_chk(`ASM_REG_MREV, 16'h3c3c);
		reg_chk(`ASM_REG_SECST, 16'h00a1);
		run(`ASM_CMD_UNLOCK, 16'h0000, 8'h11, 8'h40);
		reg_chk(`ASM_REG_SECST, 16'h00a1);
		hreset();
		reg_chk(`ASM_REG_SECST, 16'h00a3);
		run(`ASM_CMD_UNLOCK, 16'h0001, 8'h3c, 8'h40);
		reg_chk(`ASM_REG_SECST, 16'h00a1);
		// Attempt counter down to exhaustion
		hreset();
		for (int i = 4; i >= 0; i--) begin
			run(`ASM_CMD_UNLOCK, 16'h0000, 8'h11, 8'h41);
			reg_chk(`ASM_REG_SECST, 16'((i << 5) | 3));
		end
		run(`ASM_CMD_UNLOCK, 16'h0000, 8'h5a, 8'h41);
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		run(`ASM_CMD_ERASE, 16'h0000, 8'h5a, 8'h41);
		hreset();
		reg_chk(`ASM_REG_SECST, 16'h00a3);
		run(`ASM_CMD_UNLOCK, 16'h0000, 8'h5a, 8'h40);
		// Maximum level: master no longer unlocks
		run(`ASM_CMD_SETPW, 16'h0100, 8'h77, 8'h40);
		reg_chk(`ASM_REG_SECST, 16'h00a9);
		hreset();
		run(`ASM_CMD_UNLOCK, 16'h0001, 8'h3c, 8'h41);
		reg_chk(`ASM_REG_SECST, 16'h00ab);
		run(`ASM_CMD_UNLOCK, 16'h0000, 8'h77, 8'h40);
		// Erase needs a directly preceding prepare
		run(`ASM_CMD_ERASE, 16'h0000, 8'h77, 8'h41);
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		reg_chk(`ASM_REG_SECST, 16'h00b9);
		asm_host_model_i.send(8'h90, 16'h0000, 8'h00);
		repeat (4) @(posedge clk);
		reg_chk(`ASM_REG_SECST, 16'h00a9);
		run(`ASM_CMD_ERASE, 16'h0000, 8'h77, 8'h41);
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		run(`ASM_CMD_ERASE, 16'h0000, 8'h11, 8'h41);
		reg_chk(`ASM_REG_SECST, 16'h0089);
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		run(`ASM_CMD_ERASE, 16'h0002, 8'h77, 8'h41);
		// Wipe outcomes: failed enhanced, faulted normal, good normal
		reg_write(`ASM_REG_CTRL, 16'h0002);
		reg_chk(`ASM_REG_CTRL, 16'h0002);
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		run(`ASM_CMD_ERASE, 16'h0002, 8'h77, 8'h41);
		check("erase_enh", 16'h0001, {15'h0000, enh_seen});
		erase_fault <= 1'b1;
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		run(`ASM_CMD_ERASE, 16'h0000, 8'h77, 8'h61);
		erase_fault <= 1'b0;
		erase_ok    <= 1'b1;
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h40);
		run(`ASM_CMD_ERASE, 16'h0000, 8'h77, 8'h40);
		check("erase_enh", 16'h0000, {15'h0000, enh_seen});
		reg_chk(`ASM_REG_SECST, 16'h0000, 16'h0003);
		// Master still stored once a new user password is set
		run(`ASM_CMD_SETPW, 16'h0000, 8'h5a, 8'h40);
		hreset();
		reg_chk(`ASM_REG_SECST, 16'h00a3);
		run(`ASM_CMD_UNLOCK, 16'h0001, 8'h3c, 8'h40);
		// Frozen mode refuses unlock, erase prepare and erase unit
		reg_write(`ASM_REG_CTRL, 16'h0001);
		reg_chk(`ASM_REG_SECST, 16'h0004, 16'h0004);
		run(`ASM_CMD_UNLOCK, 16'h0000, 8'h5a, 8'h41);
		run(`ASM_CMD_PREP, 16'h0000, 8'h00, 8'h41);
		run(`ASM_CMD_ERASE, 16'h0000, 8'h5a, 8'h41);
		hreset();
		reg_chk(`ASM_REG_SECST, 16'h0000, 16'h0004);
		finish_test();
	end
endmodule
